// file: core/cpc_pkg.sv
// constants, register map and field layout of the clock path configuration
// Summary of operation
// (R01) Power-up and every reset set the PLL power-mode field to 01b: PLL off.
// (R02) Power-mode code 00b runs the PLL in normal operation, powered on.
// (R03) The VCO divider ratio field resets to 010b, a divide ratio of four.
// (R04) The VCO divider offers ratios two to six; two is its least division.
// (R05) Bypass bit zero, the default, routes the source through the divider.
// (R06) Source-select bit zero, the default, takes the external clock input.
// (R07) Written values wait until 0x01 is written to the update register.
// (R08) PFD polarity bit 7: zero is positive polarity, one is negative.
// (R09) PLL on with the external input: internal VCO off, input to prescaler.
// (R10) Software sets normal power mode before using the PLL with an ext VCO.
// (R11) Software keeps the channel-divider frequency at or below 1600 MHz.
// (R12) Software programs reference, dividers, polarity and pump current.
// (R13) The active-low chip reset returns all registers to their defaults.
// (R14) The update bit clears itself once the pending values are applied.
package cpc_pkg;
  // offsets are register indices: the bus byte address is four times one,
  // since several printed offsets are not word aligned
  localparam logic [11:0] CPC_OFS_PLL_PWR   = 12'h010;
  localparam logic [11:0] CPC_OFS_VCO_DIV   = 12'h1e0;
  localparam logic [11:0] CPC_OFS_PATH_SEL  = 12'h1e1;
  localparam logic [11:0] CPC_OFS_UPDATE    = 12'h232;
  localparam logic [11:0] CPC_OFS_ACTIVE    = 12'h240;
  localparam int          CPC_BIT_POLARITY  = 7;
  localparam int          CPC_BIT_BYPASS    = 0;
  localparam int          CPC_BIT_SRC_VCO   = 1;
  localparam logic [7:0]  CPC_RST_PLL_PWR   = 8'h01;
  localparam logic [7:0]  CPC_RST_VCO_DIV   = 8'h02;
  localparam logic [7:0]  CPC_RST_PATH_SEL  = 8'h00;
  localparam logic [7:0]  CPC_UPDATE_CODE   = 8'h01;
  localparam logic [1:0]  CPC_PWR_NORMAL    = 2'b00;
  localparam logic [1:0]  CPC_PWR_ASYNC_PD  = 2'b01;
  localparam logic [2:0]  CPC_RATIO_BASE    = 3'h2;
  localparam logic [2:0]  CPC_CODE_MAX      = 3'h4;
  localparam logic [1:0]  CPC_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  CPC_RESP_SLVERR   = 2'b10;
endpackage

// file: core/cpc_reg_if.sv
// register access strobes between the bus slave and the configuration core
`timescale 1ns/10ps
`default_nettype none
interface cpc_reg_if;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;
  logic [11:0] rd_addr;
  logic [7:0]  rd_data;
  logic        rd_hit;
  logic        wr_hit;
  modport bus (output wr_en, wr_addr, wr_data, rd_addr,
               input rd_data, rd_hit, wr_hit);
  modport core (input wr_en, wr_addr, wr_data, rd_addr,
                output rd_data, rd_hit, wr_hit);
endinterface
`default_nettype wire

// file: core/cpc_axil_slave.sv
// axi4-lite slave that turns bus cycles into register strobes
`timescale 1ns/10ps
`default_nettype none
module cpc_axil_slave
  import cpc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  cpc_reg_if.bus           rif
);
  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] aw_q;
  logic [7:0]  wd_q;
  logic        wl_q;

  // each half is taken once and held until the response is accepted
  assign awready = !aw_held_q && !bvalid;
  assign wready  = !w_held_q && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_q      <= 12'h000;
      wd_q      <= 8'h00;
      wl_q      <= 1'b0;
    end
    else if (aw_held_q && w_held_q)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_q <= 1'b1;
        aw_q      <= {2'b00, awaddr[11:2]};  // byte address to index
      end
      if (wvalid && wready)
      begin
        w_held_q <= 1'b1;
        wd_q     <= wdata[7:0];
        wl_q     <= wstrb[0];
      end
    end
  end

  // one write strobe when both halves are present and lane 0 is enabled; lane 0 holds the data
  assign rif.wr_en   = aw_held_q && w_held_q && wl_q;
  assign rif.wr_addr = aw_q;
  assign rif.wr_data = wd_q;
  assign rif.rd_addr = {2'b00, araddr[11:2]};

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      bvalid <= 1'b0;
      bresp  <= CPC_RESP_OKAY;
    end
    else if (aw_held_q && w_held_q)
    begin
      bvalid <= 1'b1;
      bresp  <= rif.wr_hit ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // read data is latched at address acceptance; unmapped reads zero
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= CPC_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rif.rd_data};
      rresp  <= rif.rd_hit ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule // cpc_axil_slave
`default_nettype wire

// file: core/cpc_path_cfg.sv
// clock path configuration: pending and active registers, path controls
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cpc_path_cfg
  import cpc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        chip_reset_n,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             pll_power_on,
  output logic             vco_power_on,
  output logic             pfd_negative,
  output logic [2:0]       vco_div_ratio,
  output logic             vco_div_in_path,
  output logic             dist_src_vco,
  output logic             prescaler_from_ext
);
  cpc_reg_if rif ();

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       cfg_rst;
  logic [7:0] pend_pwr_q;
  logic [7:0] pend_div_q;
  logic [7:0] pend_sel_q;
  logic [7:0] upd_q;
  logic [7:0] act_pwr_q;
  logic [7:0] act_div_q;
  logic [7:0] act_sel_q;
  logic [2:0] ratio_d;

  cpc_axil_slave u_slave (
    .mclk    (mclk),
    .reset   (reset),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif)
  );

  // chip reset pin comes from outside: two flops before use
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end
    else
    begin
      rst_meta_q <= chip_reset_n;
      rst_sync_q <= rst_meta_q;
    end
  end

  // either reset restores defaults; the pin adds two cycles of latency
  assign cfg_rst = reset || !rst_sync_q;  // R13

  // write decode; only the mapped offsets answer okay
  always_comb
  begin
    unique case (rif.wr_addr)
      CPC_OFS_PLL_PWR, CPC_OFS_VCO_DIV, CPC_OFS_PATH_SEL, CPC_OFS_UPDATE,
      CPC_OFS_ACTIVE: rif.wr_hit = 1'b1;
      default:        rif.wr_hit = 1'b0;
    endcase
  end

  // pending copies: software writes land here and drive nothing yet
  always_ff @(posedge mclk)
  begin
    if (cfg_rst)
    begin
      pend_pwr_q <= CPC_RST_PLL_PWR;   // R01
      pend_div_q <= CPC_RST_VCO_DIV;   // R03
      pend_sel_q <= CPC_RST_PATH_SEL;  // R05 R06
    end
    else if (rif.wr_en)
    begin
      if (rif.wr_addr == CPC_OFS_PLL_PWR)
        pend_pwr_q <= rif.wr_data;
      if (rif.wr_addr == CPC_OFS_VCO_DIV)
        pend_div_q <= {5'h00, rif.wr_data[2:0]};
      if (rif.wr_addr == CPC_OFS_PATH_SEL)
        pend_sel_q <= {6'h00, rif.wr_data[1:0]};
    end
  end

  // update register: set by a write of 0x01, cleared on the same edge that makes the copy
  always_ff @(posedge mclk)
  begin
    if (cfg_rst)
      upd_q <= 8'h00;
    else if (rif.wr_en && rif.wr_addr == CPC_OFS_UPDATE
             && rif.wr_data == CPC_UPDATE_CODE)
      upd_q <= CPC_UPDATE_CODE;  // R07
    else
      upd_q <= 8'h00;  // R14
  end

  // active copies follow the pending ones only on an update
  always_ff @(posedge mclk)
  begin
    if (cfg_rst)
    begin
      act_pwr_q <= CPC_RST_PLL_PWR;   // R01
      act_div_q <= CPC_RST_VCO_DIV;   // R03
      act_sel_q <= CPC_RST_PATH_SEL;  // R05 R06
    end
    else if (upd_q == CPC_UPDATE_CODE)
    begin
      act_pwr_q <= pend_pwr_q;  // R07
      act_div_q <= pend_div_q;
      act_sel_q <= pend_sel_q;
    end
  end

  // codes above the last legal one clamp to divide-by-six
  always_comb
  begin
    if (act_div_q[2:0] > CPC_CODE_MAX)
      ratio_d = 3'(CPC_RATIO_BASE + CPC_CODE_MAX);  // R04
    else
      ratio_d = 3'(CPC_RATIO_BASE + act_div_q[2:0]);  // R04
  end

  // path controls are registered so they never glitch on an update
  always_ff @(posedge mclk)
  begin
    if (cfg_rst)
    begin
      pll_power_on       <= 1'b0;
      vco_power_on       <= 1'b0;
      pfd_negative       <= 1'b0;
      vco_div_ratio      <= 3'(CPC_RATIO_BASE + CPC_RST_VCO_DIV[2:0]);
      vco_div_in_path    <= 1'b1;
      dist_src_vco       <= 1'b0;
      prescaler_from_ext <= 1'b0;
    end
    else
    begin
      pll_power_on  <= act_pwr_q[1:0] == CPC_PWR_NORMAL;  // R02
      pfd_negative  <= act_pwr_q[CPC_BIT_POLARITY];  // R08
      vco_div_ratio <= ratio_d;
      vco_div_in_path <= !act_sel_q[CPC_BIT_BYPASS];  // R05
      dist_src_vco  <= act_sel_q[CPC_BIT_SRC_VCO];  // R06
      // external input routing keeps the internal vco dark
      vco_power_on  <= act_pwr_q[1:0] == CPC_PWR_NORMAL
                       && act_sel_q[CPC_BIT_SRC_VCO];  // R09
      prescaler_from_ext <= act_pwr_q[1:0] == CPC_PWR_NORMAL
                            && !act_sel_q[CPC_BIT_SRC_VCO];  // R09
    end
  end

  // read mux: pending values, update bit and the active snapshot
  always_comb
  begin
    rif.rd_hit = 1'b1;
    unique case (rif.rd_addr)
      CPC_OFS_PLL_PWR:  rif.rd_data = pend_pwr_q;
      CPC_OFS_VCO_DIV:  rif.rd_data = pend_div_q;
      CPC_OFS_PATH_SEL: rif.rd_data = pend_sel_q;
      CPC_OFS_UPDATE:   rif.rd_data = upd_q;  // R14
      CPC_OFS_ACTIVE:   rif.rd_data = {act_pwr_q[CPC_BIT_POLARITY],
                                       act_sel_q[1:0], act_div_q[2:0],
                                       act_pwr_q[1:0]};
      default:
      begin
        rif.rd_data = 8'h00;
        rif.rd_hit  = 1'b0;
      end
    endcase
  end
endmodule // cpc_path_cfg
`default_nettype wire

// file: testbench/cpc_path_cfg_properties.sv
// checker on the ports of the clock path configuration
`timescale 1ns/10ps
`default_nettype none
module cpc_path_cfg_props
  import cpc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        chip_reset_n,
  input wire logic [11:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        pll_power_on,
  input wire logic        vco_power_on,
  input wire logic        pfd_negative,
  input wire logic [2:0]  vco_div_ratio,
  input wire logic        vco_div_in_path,
  input wire logic        dist_src_vco,
  input wire logic        prescaler_from_ext
);
  logic       hit;
  logic [4:0] hist_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // update code taken; lanes are not looked at, the bench sets them all
  assign hit = awvalid && awready && wvalid && wready
    && awaddr == {CPC_OFS_UPDATE[9:0], 2'b00}
    && wdata[7:0] == CPC_UPDATE_CODE;
  // recent update writes, so any move of the outputs has a cause
  always_ff @(posedge mclk)
  begin
    if (reset)
      hist_q <= 5'h00;
    else
      hist_q <= {hist_q[3:0], hit};
  end
  property p_rst;
    disable iff (1'b0) reset |=> !pll_power_on && !pfd_negative
      && vco_div_ratio == 3'h4 && vco_div_in_path && !dist_src_vco;
  endproperty
  property p_upd;
    disable iff (reset || !chip_reset_n)
    !$stable({pll_power_on, pfd_negative, vco_div_ratio, vco_div_in_path,
      dist_src_vco}) |-> |hist_q[4:2] || $past(reset)
      || !$past(chip_reset_n, 4);
  endproperty
  property p_wr;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  property p_bh;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_rd;
    arvalid && arready |-> ##[1:2] rvalid;
  endproperty
  property p_rh;
    rvalid && !rready |=> rvalid;
  endproperty
  property p_ar;
    rvalid |-> !arready;
  endproperty
  property p_pth;
    prescaler_from_ext == (pll_power_on && !dist_src_vco)
      && vco_power_on == (pll_power_on && dist_src_vco);
  endproperty
  property p_rat;
    vco_div_ratio >= 3'h2 && vco_div_ratio <= 3'h6;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_upd: assert property (p_upd) else $error("output moved");
  a_wr: assert property (p_wr) else $error("no write reply");
  a_bh: assert property (p_bh) else $error("write reply lost");
  a_rd: assert property (p_rd) else $error("no read reply");
  a_rh: assert property (p_rh) else $error("read reply lost");
  a_ar: assert property (p_ar) else $error("read taken early");
  a_pth: assert property (p_pth) else $error("bad vco routing");
  a_rat: assert property (p_rat) else $error("bad ratio");
  c_upd: cover property (hit);
  c_err: cover property (bvalid && bready && bresp == 2'b10);
  c_vco: cover property (vco_power_on);
endmodule // cpc_path_cfg_props
bind cpc_path_cfg cpc_path_cfg_props i_cpc_path_cfg_props
(
  .mclk, .reset, .chip_reset_n, .awaddr, .awvalid, .awready, .wdata,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
  .rvalid, .rready, .pll_power_on, .vco_power_on, .pfd_negative,
  .vco_div_ratio, .vco_div_in_path, .dist_src_vco, .prescaler_from_ext
);
`default_nettype wire

// file: testbench/clock_path_config_test.sv
// self-checking bench for the clock path configuration
`timescale 1ns/10ps
`default_nettype none
module clock_path_config_test import cpc_pkg::*;;
  logic        mclk = 1'b0, reset = 1'b1, chip_reset_n = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, p, s;
  logic [2:0]  vco_div_ratio, c;
  logic        awready, wready, bvalid, arready, rvalid, pol;
  logic        pll_power_on, vco_power_on, pfd_negative, vco_div_in_path;
  logic        dist_src_vco, prescaler_from_ext;
  logic [8:0]  outs, prev;
  logic [33:0] q[$];
  int          miscompares = 0, check_count = 0;
  // block under test, bus inputs other than wstrb driven by the tasks below
  cpc_path_cfg i_cpc_path_cfg
  (
    .mclk, .reset, .chip_reset_n, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pll_power_on,
    .vco_power_on, .pfd_negative, .vco_div_ratio, .vco_div_in_path,
    .dist_src_vco, .prescaler_from_ext
  );
  assign outs = {pll_power_on, vco_power_on, pfd_negative, vco_div_ratio,
    vco_div_in_path, dist_src_vco, prescaler_from_ext};
  initial forever #12.5 mclk = ~mclk;
  // expected path controls for a programmed set
  function automatic logic [8:0] ex(logic [1:0] pw, logic pl,
    logic [2:0] cd, logic [1:0] sl);
    logic on;
    on = (pw == 2'h0);
    return {on, on & sl[1], pl, (cd > 3'h4) ? 3'h6 : cd + 3'h2, !sl[0],
      sl[1], on & !sl[1]};
  endfunction
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one bus cycle; the reply is noted now and compared by the monitor
  task automatic xf(input logic w, input logic [11:0] a,
    input logic [7:0] d, input logic [33:0] e);
    int n;
    q.push_back(e);
    // a is the register index; the bus carries four times it
    awaddr <= {a[9:0], 2'b00};
    araddr <= {a[9:0], 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (w ? (bvalid && bready) : (rvalid && rready))
        break;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (arready)
        arvalid <= 1'b0;
      // random stalls on the reply side, held once raised
      bready <= w & (bready | 1'($urandom));
      rready <= !w & (rready | 1'($urandom));
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 40)
    begin
      miscompares++;
      summarize();
    end
  endtask
  // replies are matched against the oldest note
  always @(posedge mclk)
  begin
    if (bvalid && bready)
      chk({bresp, 32'h0000_0000}, q.pop_front());
    if (rvalid && rready)
      chk({rresp, rdata}, q.pop_front());
  end
  initial
  begin
    void'($urandom(32'h2869_d46f));
    prev = ex(2'h1, 1'b0, 3'h2, 2'h0);
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk(outs, prev);
    xf(1'b0, CPC_OFS_PLL_PWR, 8'h00, 34'h1);
    xf(1'b0, CPC_OFS_VCO_DIV, 8'h00, 34'h2);
    xf(1'b0, CPC_OFS_PATH_SEL, 8'h00, 34'h0);
    xf(1'b0, 12'h300, 8'h00, {CPC_RESP_SLVERR, 32'h0000_0000});
    xf(1'b1, 12'h300, 8'h5a, {CPC_RESP_SLVERR, 32'h0000_0000});
    // ten random settings of divider code, polarity, power mode and select
    repeat (10)
    begin
      p = 2'($urandom);
      pol = 1'($urandom);
      c = 3'($urandom);
      s = 2'($urandom);
      xf(1'b1, CPC_OFS_PLL_PWR, {pol, 5'h00, p}, 34'h0);
      xf(1'b1, CPC_OFS_VCO_DIV, {5'h00, c}, 34'h0);
      xf(1'b1, CPC_OFS_PATH_SEL, {6'h00, s}, 34'h0);
      xf(1'b0, CPC_OFS_PLL_PWR, 8'h00, {26'h0, pol, 5'h00, p});
      chk(outs, prev);
      xf(1'b1, CPC_OFS_UPDATE, 8'h01, 34'h0);
      repeat (3) @(posedge mclk);
      prev = ex(p, pol, c, s);
      chk(outs, prev);
      xf(1'b0, CPC_OFS_ACTIVE, 8'h00, {26'h0, pol, s, c, p});
      xf(1'b0, CPC_OFS_UPDATE, 8'h00, 34'h0);
    end
    // chip reset pin held low well beyond its synchroniser
    chip_reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    chip_reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(outs, ex(2'h1, 1'b0, 3'h2, 2'h0));
    // lane zero off: the write is answered but must not land
    wstrb <= 4'he;
    xf(1'b1, CPC_OFS_VCO_DIV, 8'h05, 34'h0);
    wstrb <= 4'hf;
    xf(1'b0, CPC_OFS_VCO_DIV, 8'h00, 34'h2);
    summarize();
  end
endmodule // clock_path_config_test
`default_nettype wire
